/* File: crrs_cfg.svh */
/*
  Opcode patterns, cycle counts and reset values for the call, return
  and restart sequencer. Assumes inclusion by bare name, before use.
*/
`ifndef CRRS_CFG_SVH
`define CRRS_CFG_SVH

// ============================================================
// Opcodes and prefixes
`define OP_CALL      8'hCD
`define OP_RET       8'hC9
`define OP_SVC_RET   8'h4D
`define OP_NMI_RET   8'h45
`define OP_ADD_IMM   8'hC6
`define OP_ADC_IMM   8'hCE
`define OP_AND_IMM   8'hE6
`define PFX_EXT      8'hED
`define PFX_BIT      8'hCB
`define PFX_IDX_X    8'hDD
`define PFX_IDX_Y    8'hFD

// ============================================================
// Opcode field patterns
`define TOP_COND     2'h3
`define TOP_GROUP1   2'h1
`define TOP_GROUP0   2'h0
`define LO_CCALL     3'h4
`define LO_CRET      3'h0
`define LO_RST       3'h7
`define HI_ADD       5'h10
`define HI_ADC       5'h11
`define HI_AND       5'h14
`define NIB_ADD16    4'h9
`define NIB_ADC16    4'hA
`define OPND_MEM     3'h6

// ============================================================
// Flag bit positions
`define FLG_SIGN     7
`define FLG_ZERO     6
`define FLG_PAR      2
`define FLG_CARRY    0

// ============================================================
// Clock states per machine cycle, counted from zero
`define T_CAP        3'h2
`define T_LAST_MEM   3'h2
`define T_LAST_OP    3'h3
`define T_LAST_FETCH 3'h3
`define T_LAST_LONG  3'h4

// ============================================================
// Reset values and unit constants
`define PC_RST       16'h0000
`define SP_RST       16'hFFFF
`define ONE16        16'h0001
`define ONE8         8'h01

`endif

/* File: crrs_pkg.sv */
/*
  Types of the call, return and restart sequencer: states, decoded
  instruction record and processor bus record. Assumes nothing.
*/
package crrs_pkg;

    // ========================================================
    // Machine cycle states
    typedef enum logic [5:0] {
        ST_FETCH   = 6'h01,
        ST_IMM     = 6'h02,
        ST_POP_LO  = 6'h04,
        ST_POP_HI  = 6'h08,
        ST_PUSH_HI = 6'h10,
        ST_PUSH_LO = 6'h20
    } crrs_state_t;

    // ========================================================
    // Pending sequence kinds
    typedef enum logic [2:0] {
        K_NONE, K_CALL, K_RET, K_NONMASKABLE_RETURN_OP, K_IMM, K_DISP, K_CBD, K_CBOP
    } crrs_kind_t;

    typedef enum logic [2:0] {
        CLS_NONE, CLS_ADD, CLS_ADC, CLS_AND, CLS_ADD16, CLS_ADC16, CLS_BIT
    } crrs_cls_t;

    typedef enum logic [1:0] {
        IDX_NONE, IDX_X, IDX_Y
    } crrs_idx_t;

    typedef struct packed {
        logic      valid;
        crrs_cls_t cls;
        logic      imm;
        logic [2:0] opnd;
        logic [2:0] bitn;
        logic [1:0] pair;
        crrs_idx_t idx;
        logic [7:0] data;
    } crrs_dec_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        rd;
        logic        wr;
        logic        m1;
    } crrs_bus_t;

endpackage : crrs_pkg

/* File: crrs_seq.sv */
/*
  Call, return and restart sequencer with a partial opcode decoder.
  Assumes a memory that answers a read in the cycle its strobe rises
  and takes a write while the write strobe is high; flags come from
  logic on the same clock. One clock cycle is one clock state.
*/
// Summary of operation
// - Plain call: five machine cycles, 17 states, split 4,3,4,3,3.
// - Taken call pushes high at sp-1, low at sp-2, then jumps.
// - Conditional call: taken 17 states, not taken 10 states as 4,3,3.
// - Plain return pops low then high, sp plus two, 10 states.
// - Conditional return pops when true, else no stack access.
// - Conditional return: taken 11 states as 5,3,3, else 5 states.
// - Service return acts as plain return, own opcode, 14 states.
// - Nonmaskable return pops and restores interrupt enable, 14 states.
// - Restart pushes counter, sp minus two, jumps to page zero vector.
// - Restart selector codes 0 to 7 give vectors 00H to 38H.
// - 88 to 8F add with carry from register; CE adds immediate.
// - ED 4A to 7A: 16-bit add with carry into pointer pair.
// - 80 to 87 add; C6 immediate add; 09 to 39 16-bit add.
// - DD and FD redirect pointer uses to index registers.
// - A0 to A7 conjunction; E6 conjunction with immediate.
// - CB 40 to 7F bit test: bit number 5:3, operand 2:0.
// - Indexed bit test: prefix, CB, displacement, then operation byte.
// - Conditional call holds condition in bits 5:3, C4 to FC.
`timescale 1ns/100ps
`include "crrs_cfg.svh"

module crrs_seq (
    // Clock and reset
    input  wire logic              sys_clk_i,
    input  wire logic              sys_rst_i,
    // Processor bus
    input  wire logic [7:0]        mem_rdata_i,
    output crrs_pkg::crrs_bus_t    bus_o,
    // Core state
    input  wire logic [7:0]        flags_i,
    input  wire logic              nmi_accept_i,
    output logic                   iff1_o,
    output logic [15:0]            pc_o,
    output logic [15:0]            sp_o,
    // Decoder results
    output crrs_pkg::crrs_dec_t    dec_o,
    output logic                   service_ret_o
);

    // ========================================================
    // State
    crrs_pkg::crrs_state_t state_r, state_nxt;
    crrs_pkg::crrs_kind_t  kind_r, kind_nxt;
    crrs_pkg::crrs_idx_t   idx_r, idx_nxt;
    crrs_pkg::crrs_dec_t   dec_r, dec_nxt;
    crrs_pkg::crrs_bus_t   bus_r, bus_nxt;
    logic [2:0]  tcnt_r, tcnt_nxt;
    logic [7:0]  ir_r, ir_nxt;
    logic [7:0]  lo_r, lo_nxt;
    logic [7:0]  hi_r, hi_nxt;
    logic [15:0] pc_r, pc_nxt;
    logic [15:0] sp_r, sp_nxt;
    logic        opd_r, opd_nxt;
    logic        taken_r, taken_nxt;
    logic        ext_r, ext_nxt;
    logic        cb_r, cb_nxt;
    logic        iff1_r, iff1_nxt;
    logic        iff2_r, iff2_nxt;
    logic        svc_r, svc_nxt;
    logic [7:0]  rd_s1_r;
    logic [7:0]  rd_s2_r;

    // ========================================================
    // Condition test
    function automatic logic cc_true(input logic [2:0] c, input logic [7:0] f);
        logic v;
        v = 1'b0;
        unique case (c[2:1])
            2'h0: v = f[`FLG_ZERO];
            2'h1: v = f[`FLG_CARRY];
            2'h2: v = f[`FLG_PAR];
            2'h3: v = f[`FLG_SIGN];
        endcase
        return v == c[0];
    endfunction : cc_true

    // ========================================================
    // Opcode decode on the instruction register
    wire       plain    = !ext_r && !cb_r;
    wire       top_cond = ir_r[7:6] == `TOP_COND;
    wire       is_call  = ir_r == `OP_CALL;
    wire       is_ccall = top_cond && ir_r[2:0] == `LO_CCALL;
    wire       is_ret   = ir_r == `OP_RET;
    wire       is_cret  = top_cond && ir_r[2:0] == `LO_CRET;
    wire       is_rst   = top_cond && ir_r[2:0] == `LO_RST;
    wire       cond_ok  = cc_true(ir_r[5:3], flags_i);
    wire       is_add   = ir_r[7:3] == `HI_ADD;
    wire       is_adc   = ir_r[7:3] == `HI_ADC;
    wire       is_and   = ir_r[7:3] == `HI_AND;
    wire       is_alu   = is_add || is_adc || is_and;
    wire       is_imm   = ir_r == `OP_ADD_IMM || ir_r == `OP_ADC_IMM
                          || ir_r == `OP_AND_IMM;
    wire       is_add16 = ir_r[7:6] == `TOP_GROUP0 && ir_r[3:0] == `NIB_ADD16;
    wire       is_adc16 = ir_r[7:6] == `TOP_GROUP1 && ir_r[3:0] == `NIB_ADC16;
    wire       is_bit   = ir_r[7:6] == `TOP_GROUP1;
    wire       mem_opnd = ir_r[2:0] == `OPND_MEM;
    wire       long_fch = plain && (is_cret || is_rst);
    wire [7:0] rst_vec  = {2'h0, ir_r[5:3], 3'h0};

    wire crrs_pkg::crrs_cls_t alu_cls =
        is_add ? crrs_pkg::CLS_ADD : is_adc ? crrs_pkg::CLS_ADC : crrs_pkg::CLS_AND;
    wire crrs_pkg::crrs_cls_t imm_cls =
        ir_r == `OP_ADD_IMM ? crrs_pkg::CLS_ADD :
        ir_r == `OP_ADC_IMM ? crrs_pkg::CLS_ADC : crrs_pkg::CLS_AND;

    // ========================================================
    // Cycle timing
    wire in_fetch = state_r == crrs_pkg::ST_FETCH;
    wire in_imm   = state_r == crrs_pkg::ST_IMM;
    wire in_pop   = state_r == crrs_pkg::ST_POP_LO || state_r == crrs_pkg::ST_POP_HI;
    wire in_push  = state_r == crrs_pkg::ST_PUSH_HI || state_r == crrs_pkg::ST_PUSH_LO;
    wire cap      = (in_fetch || in_imm || in_pop) && tcnt_r == `T_CAP;
    wire op_long  = in_imm && kind_r == crrs_pkg::K_CALL && opd_r && taken_r;
    wire [2:0] t_last = in_fetch ? (long_fch ? `T_LAST_LONG : `T_LAST_FETCH)
                      : op_long ? `T_LAST_OP : `T_LAST_MEM;
    wire last     = tcnt_r == t_last;

    // ========================================================
    // Sequencer next state
    always_comb begin
        state_nxt = state_r;
        tcnt_nxt  = tcnt_r + 3'h1;
        kind_nxt  = kind_r;
        idx_nxt   = idx_r;
        ir_nxt    = ir_r;
        lo_nxt    = lo_r;
        hi_nxt    = hi_r;
        pc_nxt    = pc_r;
        sp_nxt    = sp_r;
        opd_nxt   = opd_r;
        taken_nxt = taken_r;
        ext_nxt   = ext_r;
        cb_nxt    = cb_r;
        iff1_nxt  = iff1_r;
        iff2_nxt  = iff2_r;
        svc_nxt   = 1'b0;
        dec_nxt   = dec_r;
        dec_nxt.valid = 1'b0;
        if (nmi_accept_i) begin
            iff2_nxt = iff1_r;
            iff1_nxt = 1'b0;
        end
        if (cap) begin
            pc_nxt = in_pop ? pc_r : pc_r + `ONE16;
            sp_nxt = in_pop ? sp_r + `ONE16 : sp_r;
            if (in_fetch) begin
                ir_nxt = rd_s2_r;
            end
        end
        if (last) begin
            tcnt_nxt = 3'h0;
            dec_nxt.idx  = idx_r;
            dec_nxt.imm  = 1'b0;
            dec_nxt.opnd = ir_r[2:0];
            dec_nxt.bitn = ir_r[5:3];
            dec_nxt.pair = ir_r[5:4];
            dec_nxt.data = rd_s2_r;
            unique case (state_r)
                crrs_pkg::ST_FETCH: begin
                    ext_nxt = 1'b0;
                    cb_nxt  = 1'b0;
                    idx_nxt = crrs_pkg::IDX_NONE;
                    opd_nxt = 1'b0;
                    if (ext_r) begin
                        if (is_adc16) begin
                            dec_nxt.valid = 1'b1;
                            dec_nxt.cls   = crrs_pkg::CLS_ADC16;
                        end else if (ir_r == `OP_SVC_RET) begin
                            svc_nxt   = 1'b1;
                            kind_nxt  = crrs_pkg::K_RET;
                            state_nxt = crrs_pkg::ST_POP_LO;
                        end else if (ir_r == `OP_NMI_RET) begin
                            kind_nxt  = crrs_pkg::K_NONMASKABLE_RETURN_OP;
                            state_nxt = crrs_pkg::ST_POP_LO;
                        end
                    end else if (cb_r) begin
                        dec_nxt.valid = is_bit;
                        dec_nxt.cls   = crrs_pkg::CLS_BIT;
                    end else if (ir_r == `PFX_IDX_X) begin
                        idx_nxt = crrs_pkg::IDX_X;
                    end else if (ir_r == `PFX_IDX_Y) begin
                        idx_nxt = crrs_pkg::IDX_Y;
                    end else if (ir_r == `PFX_EXT) begin
                        ext_nxt = 1'b1;
                    end else if (ir_r == `PFX_BIT) begin
                        if (idx_r != crrs_pkg::IDX_NONE) begin
                            idx_nxt   = idx_r;
                            kind_nxt  = crrs_pkg::K_CBD;
                            state_nxt = crrs_pkg::ST_IMM;
                        end else begin
                            cb_nxt = 1'b1;
                        end
                    end else if (is_call || is_ccall) begin
                        kind_nxt  = crrs_pkg::K_CALL;
                        taken_nxt = is_call || cond_ok;
                        state_nxt = crrs_pkg::ST_IMM;
                    end else if (is_ret || (is_cret && cond_ok)) begin
                        kind_nxt  = crrs_pkg::K_RET;
                        state_nxt = crrs_pkg::ST_POP_LO;
                    end else if (is_rst) begin
                        kind_nxt  = crrs_pkg::K_CALL;
                        lo_nxt    = rst_vec;
                        hi_nxt    = 8'h00;
                        state_nxt = crrs_pkg::ST_PUSH_HI;
                    end else if (is_alu) begin
                        if (mem_opnd && idx_r != crrs_pkg::IDX_NONE) begin
                            idx_nxt   = idx_r;
                            kind_nxt  = crrs_pkg::K_DISP;
                            state_nxt = crrs_pkg::ST_IMM;
                        end else begin
                            dec_nxt.valid = 1'b1;
                            dec_nxt.cls   = alu_cls;
                        end
                    end else if (is_imm) begin
                        kind_nxt  = crrs_pkg::K_IMM;
                        state_nxt = crrs_pkg::ST_IMM;
                    end else if (is_add16) begin
                        dec_nxt.valid = 1'b1;
                        dec_nxt.cls   = crrs_pkg::CLS_ADD16;
                    end
                end
                crrs_pkg::ST_IMM: begin
                    state_nxt = crrs_pkg::ST_FETCH;
                    idx_nxt   = crrs_pkg::IDX_NONE;
                    unique case (kind_r)
                        crrs_pkg::K_CALL: begin
                            if (!opd_r) begin
                                lo_nxt    = rd_s2_r;
                                opd_nxt   = 1'b1;
                                state_nxt = crrs_pkg::ST_IMM;
                            end else begin
                                hi_nxt = rd_s2_r;
                                if (taken_r) begin
                                    state_nxt = crrs_pkg::ST_PUSH_HI;
                                end
                            end
                        end
                        crrs_pkg::K_IMM: begin
                            dec_nxt.valid = 1'b1;
                            dec_nxt.cls   = imm_cls;
                            dec_nxt.imm   = 1'b1;
                        end
                        crrs_pkg::K_DISP: begin
                            dec_nxt.valid = 1'b1;
                            dec_nxt.cls   = alu_cls;
                        end
                        crrs_pkg::K_CBD: begin
                            lo_nxt    = rd_s2_r;
                            idx_nxt   = idx_r;
                            kind_nxt  = crrs_pkg::K_CBOP;
                            state_nxt = crrs_pkg::ST_IMM;
                        end
                        crrs_pkg::K_CBOP: begin
                            dec_nxt.valid = rd_s2_r[7:6] == `TOP_GROUP1;
                            dec_nxt.cls   = crrs_pkg::CLS_BIT;
                            dec_nxt.opnd  = rd_s2_r[2:0];
                            dec_nxt.bitn  = rd_s2_r[5:3];
                            dec_nxt.pair  = rd_s2_r[5:4];
                            dec_nxt.data  = lo_r;
                        end
                        default: begin
                            kind_nxt = crrs_pkg::K_NONE;
                        end
                    endcase
                end
                crrs_pkg::ST_POP_LO: begin
                    lo_nxt    = rd_s2_r;
                    state_nxt = crrs_pkg::ST_POP_HI;
                end
                crrs_pkg::ST_POP_HI: begin
                    pc_nxt    = {rd_s2_r, lo_r};
                    state_nxt = crrs_pkg::ST_FETCH;
                    if (kind_r == crrs_pkg::K_NONMASKABLE_RETURN_OP) begin
                        iff1_nxt = iff2_r;
                    end
                end
                crrs_pkg::ST_PUSH_HI: begin
                    sp_nxt    = sp_r - `ONE16;
                    state_nxt = crrs_pkg::ST_PUSH_LO;
                end
                crrs_pkg::ST_PUSH_LO: begin
                    sp_nxt    = sp_r - `ONE16;
                    pc_nxt    = {hi_r, lo_r};
                    state_nxt = crrs_pkg::ST_FETCH;
                end
            endcase
        end
    end

    // ========================================================
    // Bus for the coming clock state
    wire nx_fetch = state_nxt == crrs_pkg::ST_FETCH;
    wire nx_pop   = state_nxt == crrs_pkg::ST_POP_LO || state_nxt == crrs_pkg::ST_POP_HI;
    wire nx_push  = state_nxt == crrs_pkg::ST_PUSH_HI || state_nxt == crrs_pkg::ST_PUSH_LO;
    wire nx_strb  = tcnt_nxt <= `T_CAP;

    always_comb begin
        bus_nxt.rd    = (nx_fetch || nx_pop || state_nxt == crrs_pkg::ST_IMM) && nx_strb;
        bus_nxt.wr    = nx_push && nx_strb;
        bus_nxt.m1    = nx_fetch && nx_strb;
        bus_nxt.addr  = nx_push ? sp_nxt - `ONE16 : nx_pop ? sp_nxt : pc_nxt;
        bus_nxt.wdata = state_nxt == crrs_pkg::ST_PUSH_HI ? pc_nxt[15:8] : pc_nxt[7:0];
    end

    // ========================================================
    // Registers
    always_ff @(posedge sys_clk_i) begin
        rd_s1_r <= mem_rdata_i;
        rd_s2_r <= rd_s1_r;
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state_r <= crrs_pkg::ST_FETCH;
            kind_r  <= crrs_pkg::K_NONE;
            idx_r   <= crrs_pkg::IDX_NONE;
            dec_r   <= '0;
            bus_r   <= '{addr: `PC_RST, wdata: 8'h00, rd: 1'b1, wr: 1'b0, m1: 1'b1};
            tcnt_r  <= 3'h0;
            ir_r    <= 8'h00;
            lo_r    <= 8'h00;
            hi_r    <= 8'h00;
            pc_r    <= `PC_RST;
            sp_r    <= `SP_RST;
            opd_r   <= 1'b0;
            taken_r <= 1'b0;
            ext_r   <= 1'b0;
            cb_r    <= 1'b0;
            iff1_r  <= 1'b0;
            iff2_r  <= 1'b0;
            svc_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            kind_r  <= kind_nxt;
            idx_r   <= idx_nxt;
            dec_r   <= dec_nxt;
            bus_r   <= bus_nxt;
            tcnt_r  <= tcnt_nxt;
            ir_r    <= ir_nxt;
            lo_r    <= lo_nxt;
            hi_r    <= hi_nxt;
            pc_r    <= pc_nxt;
            sp_r    <= sp_nxt;
            opd_r   <= opd_nxt;
            taken_r <= taken_nxt;
            ext_r   <= ext_nxt;
            cb_r    <= cb_nxt;
            iff1_r  <= iff1_nxt;
            iff2_r  <= iff2_nxt;
            svc_r   <= svc_nxt;
        end
    end

    assign bus_o         = bus_r;
    assign dec_o         = dec_r;
    assign service_ret_o = svc_r;
    assign iff1_o        = iff1_r;
    assign pc_o          = pc_r;
    assign sp_o          = sp_r;

endmodule : crrs_seq

/* File: crrs_seq_properties.sv */
/* Concurrent checks on the sequencer ports.
   Assumes binding onto crrs_seq, one clock, synchronous reset. */
`timescale 1ns/100ps
module crrs_props (
    // Clock and reset
    input wire logic                 sys_clk_i,
    input wire logic                 sys_rst_i,
    // Watched outputs
    input wire crrs_pkg::crrs_bus_t  bus_o,
    input wire logic [15:0]          sp_o,
    input wire crrs_pkg::crrs_dec_t  dec_o,
    input wire logic                 service_ret_o
);
    // ============================================================
    // Assertions
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    wire pop_go = bus_o.rd && !bus_o.m1 && (bus_o.addr == sp_o);
    fetch_len_a: assert property ($rose(bus_o.m1) |->
        (bus_o.m1 && bus_o.rd) [*3] ##1 !bus_o.rd)
        else $error("fetch strobe length wrong");
    push_pair_a: assert property ($rose(bus_o.wr) |->
        ##3 (bus_o.wr && bus_o.addr == $past(bus_o.addr, 3) - 16'h0001))
        else $error("second push not one below first");
    push_sp_a: assert property ($rose(bus_o.wr) |->
        ##6 (bus_o.m1 && !bus_o.wr && sp_o == $past(bus_o.addr, 6) - 16'h0001))
        else $error("stack pointer or fetch wrong after push");
    sp_step_a: assert property (bus_o.m1 && $changed(sp_o) |->
        (sp_o == $past(sp_o, 4) + 16'h0002) || (sp_o == $past(sp_o, 4) - 16'h0002))
        else $error("stack pointer step not two");
    pop_pair_a: assert property ($rose(pop_go) |->
        ##3 (bus_o.rd && !bus_o.m1 && bus_o.addr == $past(bus_o.addr, 3) + 16'h0001))
        else $error("second pop not one above first");
    pop_end_a: assert property ($rose(pop_go) |->
        ##6 (bus_o.m1 && sp_o == $past(bus_o.addr, 6) + 16'h0002))
        else $error("fetch or stack pointer wrong after pop");
    svc_pulse_a: assert property (service_ret_o |=> !service_ret_o)
        else $error("service return pulse too long");
    svc_pop_a: assert property (service_ret_o |-> pop_go)
        else $error("service return pulse outside first pop");
    dec_pulse_a: assert property (dec_o.valid |=> !dec_o.valid)
        else $error("decode pulse too long");
    cover property ($rose(bus_o.wr));
    cover property ($rose(pop_go));
    cover property (dec_o.valid && dec_o.cls == crrs_pkg::CLS_BIT);
endmodule : crrs_props

/* File: crrs_mem.sv */
/* Behavioural program and stack memory on the processor bus.
   Assumes reads answer at once and writes land while wr is high. */
`timescale 1ns/100ps
module crrs_mem (
    // Clock
    input  wire logic                 sys_clk_i,
    // Processor bus
    input  wire crrs_pkg::crrs_bus_t  bus_i,
    output logic [7:0]                rdata_o
);
    // ============================================================
    // Storage
    logic [7:0] mem_r [0:65535];
    logic [7:0] last_r;
    // Released bus shows inverse of last byte
    assign rdata_o = bus_i.rd ? mem_r[bus_i.addr] : ~last_r;
    initial begin
        foreach (mem_r[k]) mem_r[k] = 8'h00;
        last_r = 8'h00;
    end
    always @(posedge sys_clk_i) begin
        if (bus_i.rd) last_r <= mem_r[bus_i.addr];
        if (bus_i.wr) mem_r[bus_i.addr] <= bus_i.wdata;
    end
endmodule : crrs_mem

/* File: test_call_return_restart_sequencer.sv */
/* Bench for the call, return and restart sequencer.
   Assumes crrs_mem as program and stack memory, no wait states. */
`timescale 1ns/100ps
`include "crrs_cfg.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
    $display("mismatch at %0t: got %h want %h", $time, g, e); end end
module test_call_return_restart_sequencer;
    // ============================================================
    // Signals and instances
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] mem_rdata_i;
    logic [7:0] flags_i = 8'h00;
    logic nmi_accept_i = 1'b0;
    crrs_pkg::crrs_bus_t bus_o;
    logic iff1_o;
    logic [15:0] pc_o;
    logic [15:0] sp_o;
    crrs_pkg::crrs_dec_t dec_o;
    logic service_ret_o;
    int failures = 0;
    int samples_checked = 0;
    int cyc = 0;
    int wd = 0;
    int flag_pos[4] = '{`FLG_ZERO, `FLG_CARRY, `FLG_PAR, `FLG_SIGN};
    always #25 sys_clk_i = ~sys_clk_i;
    crrs_seq i_crrs_seq (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .mem_rdata_i(mem_rdata_i), .bus_o(bus_o), .flags_i(flags_i),
        .nmi_accept_i(nmi_accept_i), .iff1_o(iff1_o), .pc_o(pc_o), .sp_o(sp_o),
        .dec_o(dec_o), .service_ret_o(service_ret_o));
    crrs_mem i_crrs_mem (.sys_clk_i(sys_clk_i), .bus_i(bus_o), .rdata_o(mem_rdata_i));
    // ============================================================
    // Helpers
    task automatic load(input logic [15:0] a, input logic [7:0] b[$]);
        foreach (b[k]) i_crrs_mem.mem_r[a + 16'(k)] = b[k];
    endtask : load
    function automatic logic [15:0] stk();
        return {i_crrs_mem.mem_r[16'hFFFE], i_crrs_mem.mem_r[16'hFFFD]};
    endfunction : stk
    task automatic start(input logic [7:0] f);
        @(posedge sys_clk_i);
        flags_i <= f;
        sys_rst_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        cyc = 0;
    endtask : start
    task automatic wait_to(input int t);
        repeat (t - cyc) @(posedge sys_clk_i);
        #1;
        cyc = t;
    endtask : wait_to
    task automatic at(input int t, input logic [15:0] ea);
        wait_to(t);
        `CHK({bus_o.m1, bus_o.addr}, {1'b1, ea})
    endtask : at
    task automatic dec(input crrs_pkg::crrs_cls_t c, input crrs_pkg::crrs_idx_t x,
                       input logic [5:0] v, input logic [8:0] d);
        logic [5:0] g;
        for (int n = 0; n < 20 && dec_o.valid !== 1'b1; n++) begin
            @(posedge sys_clk_i);
            #1;
        end
        g = (c == crrs_pkg::CLS_BIT) ? {dec_o.bitn, dec_o.opnd} : {2'h0, dec_o.imm, dec_o.opnd};
        if (c inside {crrs_pkg::CLS_ADD16, crrs_pkg::CLS_ADC16}) g = {4'h0, dec_o.pair};
        `CHK({dec_o.valid, dec_o.cls, dec_o.idx, g}, {1'b1, c, x, v})
        if (d[8]) `CHK(dec_o.data, d[7:0])
        @(posedge sys_clk_i);
        #1;
    endtask : dec
    // ============================================================
    // Scenarios
    task automatic t_dec;
        load(16'h0000, '{8'h8E, 8'hCE, 8'h5A, 8'hED, 8'h4A, 8'hED, 8'h7A, 8'h80, 8'hC6, 8'h33,
            8'h39, 8'hDD, 8'h09, 8'hFD, 8'h86, 8'hF0, 8'hA7, 8'hE6, 8'h0F, 8'hCB, 8'h7E,
            8'hDD, 8'hCB, 8'h05, 8'h46});
        start(8'h00);
        dec(crrs_pkg::CLS_ADC, crrs_pkg::IDX_NONE, 6'h06, 9'h000);
        dec(crrs_pkg::CLS_ADC, crrs_pkg::IDX_NONE, 6'h0E, 9'h15A);
        dec(crrs_pkg::CLS_ADC16, crrs_pkg::IDX_NONE, 6'h00, 9'h000);
        dec(crrs_pkg::CLS_ADC16, crrs_pkg::IDX_NONE, 6'h03, 9'h000);
        dec(crrs_pkg::CLS_ADD, crrs_pkg::IDX_NONE, 6'h00, 9'h000);
        dec(crrs_pkg::CLS_ADD, crrs_pkg::IDX_NONE, 6'h0E, 9'h133);
        dec(crrs_pkg::CLS_ADD16, crrs_pkg::IDX_NONE, 6'h03, 9'h000);
        dec(crrs_pkg::CLS_ADD16, crrs_pkg::IDX_X, 6'h00, 9'h000);
        dec(crrs_pkg::CLS_ADD, crrs_pkg::IDX_Y, 6'h06, 9'h1F0);
        dec(crrs_pkg::CLS_AND, crrs_pkg::IDX_NONE, 6'h07, 9'h000);
        dec(crrs_pkg::CLS_AND, crrs_pkg::IDX_NONE, 6'h0E, 9'h10F);
        dec(crrs_pkg::CLS_BIT, crrs_pkg::IDX_NONE, 6'h3E, 9'h000);
        dec(crrs_pkg::CLS_BIT, crrs_pkg::IDX_X, 6'h06, 9'h105);
        $display("test decode done");
    endtask : t_dec
    task automatic t_cond;
        logic [7:0] f;
        logic [2:0] cc;
        for (int k = 0; k < 16; k++) begin
            cc = 3'(k >> 1);
            f = 8'h00;
            f[flag_pos[cc[2:1]]] = ~(cc[0] ^ k[0]);
            load(16'h0000, '{{2'h3, cc, 3'h4}, 8'h10, 8'h00, {2'h3, cc, 3'h0}});
            load(16'h0010, '{{2'h3, cc, 3'h0}});
            start(f);
            if (k[0]) begin
                at(17, 16'h0010);
                at(28, 16'h0003);
            end else begin
                at(10, 16'h0003);
                at(15, 16'h0004);
            end
            `CHK(sp_o, 16'hFFFF)
        end
        $display("test conditional done");
    endtask : t_cond
    task automatic t_ret;
        for (int k = 0; k < 3; k++) begin
            load(16'h0000, '{8'hCD, 8'h10, 8'h00});
            load(16'h0010, '{(k == 2) ? 8'hC9 : 8'hED, (k == 1) ? 8'h45 : 8'h4D});
            start(8'h00);
            nmi_accept_i <= 1'b1;
            @(posedge sys_clk_i);
            nmi_accept_i <= 1'b0;
            cyc = 1;
            at(17, 16'h0010);
            `CHK({stk(), sp_o}, 32'h0003FFFD)
            wait_to(25);
            `CHK(service_ret_o, 1'(k == 0))
            at((k == 2) ? 27 : 31, 16'h0003);
            `CHK({iff1_o, sp_o}, 17'h0FFFF)
        end
        $display("test return done");
    endtask : t_ret
    task automatic t_rst;
        for (int t = 0; t < 8; t++) begin
            load(16'h0000, '{{2'h3, 3'(t), 3'h7}});
            start(8'h00);
            at(11, {10'h000, 3'(t), 3'h0});
            `CHK({stk(), sp_o, pc_o}, {32'h0001FFFD, 10'h000, 3'(t), 3'h0})
        end
        $display("test restart done");
    endtask : t_rst
    // ============================================================
    // Run control
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict
    always @(posedge sys_clk_i) begin
        wd <= wd + 1;
        if (wd == 5000) begin
            failures++;
            print_verdict();
        end
    end
    initial begin
        t_dec();
        t_cond();
        t_ret();
        t_rst();
        print_verdict();
    end
endmodule : test_call_return_restart_sequencer
bind crrs_seq crrs_props i_crrs_props (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .bus_o(bus_o), .sp_o(sp_o), .dec_o(dec_o), .service_ret_o(service_ret_o));
